// [design/adc_serial_control_port.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_serial_control_port (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       cs_n_i,
  input  wire logic       frame_sync_i,
  input  wire logic       io_clk_i,
  input  wire logic       data_in_i,
  input  wire logic       clock_polarity_select_i,
  input  wire logic       four_input_variant_i,
  input  wire logic [9:0] analog_code_i,
  output logic            data_out_o,
  output logic            data_out_oe_o,
  output logic            eoc_o,
  output logic [2:0]      channel_o,
  output logic            sampling_o,
  output logic            power_down_o,
  output logic            fast_rate_o
);
  // ---------------------------------------------------------------
  // Command decoding
  // ---------------------------------------------------------------
  function automatic logic converts(input logic [3:0] cmd, input logic four_var);
    logic ok;
    ok = 1'b0;
    if (cmd <= adc_port_pkg::CMD_CH_LAST) begin
      ok = ~(four_var & cmd[0]);
    end else if (cmd == adc_port_pkg::CMD_TEST_MID || cmd == adc_port_pkg::CMD_TEST_LOW ||
                 cmd == adc_port_pkg::CMD_TEST_HIGH) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic [9:0] conv_value(input logic [3:0] cmd, input logic [9:0] analog);
    logic [9:0] v;
    v = analog;
    case (cmd)
      adc_port_pkg::CMD_TEST_MID:  v = adc_port_pkg::TEST_MID_CODE;
      adc_port_pkg::CMD_TEST_LOW:  v = adc_port_pkg::TEST_LOW_CODE;
      adc_port_pkg::CMD_TEST_HIGH: v = adc_port_pkg::TEST_HIGH_CODE;
      default:                     v = analog;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic fs_lvl;
  logic clk_rise;
  logic clk_fall;
  logic din_lvl;
  logic pol_lvl;

  edge_sync #(.INIT(1'b1)) u_cs (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (cs_n_i),
    .level_o   (cs_lvl),
    .rise_o    (cs_rise),
    .fall_o    (cs_fall)
  );

  edge_sync #(.INIT(1'b1)) u_fs (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (frame_sync_i),
    .level_o   (fs_lvl),
    .rise_o    (),
    .fall_o    ()
  );

  edge_sync #(.INIT(1'b0)) u_clk (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (io_clk_i),
    .level_o   (),
    .rise_o    (clk_rise),
    .fall_o    (clk_fall)
  );

  edge_sync #(.INIT(1'b0)) u_din (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (data_in_i),
    .level_o   (din_lvl),
    .rise_o    (),
    .fall_o    ()
  );

  edge_sync #(.INIT(1'b1)) u_pol (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (clock_polarity_select_i),
    .level_o   (pol_lvl),
    .rise_o    (),
    .fall_o    ()
  );

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       active;
    logic       dsp;
    logic       armed;
    logic [4:0] main_cnt;
    logic [4:0] cap_cnt;
    logic [3:0] cmd;
    logic [9:0] shift;
    logic       oe;
    logic       sampling;
    logic       pd;
    logic       fast;
    logic [9:0] result;
  } port_t;

  port_t st_r;
  port_t st_nxt;

  logic       conv_start;
  logic       conv_abort;
  logic       cmd_done;
  logic       conv_busy;
  logic       conv_eoc;
  logic       conv_done;
  logic [9:0] conv_result;
  logic       main_edge;
  logic       out_edge;
  logic       cap_edge;

  // MSB-first command arrives on the capture edge; the other edge set drives timing.
  assign main_edge = st_r.dsp ? clk_fall : clk_rise;
  assign out_edge  = st_r.dsp ? clk_rise : clk_fall;
  assign cap_edge  = (pol_lvl ^ st_r.dsp) ? clk_rise : clk_fall;

  always_comb begin
    logic [3:0] new_cmd;
    new_cmd    = {st_r.cmd[2:0], din_lvl};
    st_nxt     = st_r;
    conv_start = 1'b0;
    conv_abort = 1'b0;
    cmd_done   = 1'b0;
    if (conv_done) begin
      st_nxt.result = conv_result;
    end
    if (cs_fall) begin
      // A fall while busy throws the conversion away; the old result stays.
      conv_abort      = conv_busy;
      st_nxt.active   = 1'b1;
      st_nxt.dsp      = ~fs_lvl;
      st_nxt.armed    = fs_lvl;
      st_nxt.main_cnt = '0;
      st_nxt.cap_cnt  = '0;
      st_nxt.cmd      = '0;
      st_nxt.shift    = st_r.result;
      st_nxt.oe       = 1'b1;
      st_nxt.sampling = 1'b0;
      st_nxt.pd       = 1'b0;
    end else if (cs_rise) begin
      st_nxt.active   = 1'b0;
      st_nxt.oe       = 1'b0;
      st_nxt.sampling = 1'b0;
      if (!st_r.dsp) begin
        st_nxt.armed    = 1'b0;
        st_nxt.main_cnt = '0;
        st_nxt.cap_cnt  = '0;
      end
    end else if (st_r.active && !cs_lvl) begin
      if (st_r.dsp && clk_fall && fs_lvl) begin
        st_nxt.armed    = 1'b1;
        st_nxt.main_cnt = '0;
        st_nxt.cap_cnt  = '0;
        st_nxt.cmd      = '0;
        st_nxt.sampling = 1'b0;
        st_nxt.shift    = st_r.result;
      end else if (st_r.armed) begin
        if (cap_edge && st_r.cap_cnt < adc_port_pkg::CMD_BITS) begin
          st_nxt.cmd     = new_cmd;
          st_nxt.cap_cnt = st_r.cap_cnt + 5'h01;
          if (st_r.cap_cnt == adc_port_pkg::CMD_LAST_IDX) begin
            cmd_done = 1'b1;
            case (new_cmd)
              adc_port_pkg::CMD_POWER_DOWN: st_nxt.pd   = 1'b1;
              adc_port_pkg::CMD_FAST_RATE:  st_nxt.fast = 1'b1;
              adc_port_pkg::CMD_SLOW_RATE:  st_nxt.fast = 1'b0;
              default:                      st_nxt.pd   = st_r.pd;
            endcase
            if (st_r.main_cnt > adc_port_pkg::SAMPLE_IDX &&
                st_r.main_cnt <= adc_port_pkg::CONVERT_IDX) begin
              // With capture just after each main edge, as in microcontroller mode with capture on falls, the command completes after the fourth main edge.
              st_nxt.sampling = converts(new_cmd, four_input_variant_i);
            end
          end
        end
        if (main_edge && st_r.main_cnt != adc_port_pkg::CNT_MAX) begin
          st_nxt.main_cnt = st_r.main_cnt + 5'h01;
          if (st_r.main_cnt == adc_port_pkg::SAMPLE_IDX) begin
            st_nxt.sampling = (st_nxt.cap_cnt == adc_port_pkg::CMD_BITS) &&
                              converts(st_nxt.cmd, four_input_variant_i);
          end
          if (st_r.main_cnt == adc_port_pkg::CONVERT_IDX) begin
            st_nxt.sampling = 1'b0;
            // Only a channel or self-test command hands over to the converter.
            conv_start = converts(st_nxt.cmd, four_input_variant_i);
          end
        end
        if (out_edge) begin
          // Zeros shift in behind the result, giving trailing zeros past ten bits.
          st_nxt.shift = {st_r.shift[8:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Converter timing
  // ---------------------------------------------------------------
  conversion_timer u_conv (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .start_i   (conv_start),
    .abort_i   (conv_abort),
    .fast_i    (st_r.fast),
    .value_i   (conv_value(st_nxt.cmd, analog_code_i)),
    .busy_o    (conv_busy),
    .eoc_o     (conv_eoc),
    .done_o    (conv_done),
    .result_o  (conv_result)
  );

  assign data_out_o    = st_r.shift[9];
  assign data_out_oe_o = st_r.oe;
  assign eoc_o         = conv_eoc;
  assign channel_o     = four_input_variant_i ? {1'b0, st_r.cmd[2:1]} : st_r.cmd[2:0];
  assign sampling_o    = st_r.sampling;
  assign power_down_o  = st_r.pd;
  assign fast_rate_o   = st_r.fast;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  mode_latch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cs_fall |=> st_r.dsp == !$past(fs_lvl))
    else $error("host type not latched at chip select fall");

  oe_on_fall_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cs_fall |=> data_out_oe_o && data_out_o == $past(st_r.result[9]))
    else $error("output not enabled with result msb");

  oe_off_rise_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cs_rise |=> !data_out_oe_o ##1 !data_out_oe_o || cs_fall)
    else $error("output not floated at chip select rise");

  start_tenth_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    conv_start |-> main_edge && st_r.main_cnt == adc_port_pkg::CONVERT_IDX && st_r.armed)
    else $error("conversion started away from the tenth edge");

  eoc_low_start_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    conv_start && !conv_abort |=> !eoc_o)
    else $error("end of conversion not low at conversion start");

  zero_tail_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    out_edge && st_r.armed && st_r.active && !cs_lvl && !cs_fall &&
    (st_r.main_cnt > adc_port_pkg::CONVERT_IDX ||
     (st_r.dsp && st_r.main_cnt == adc_port_pkg::CONVERT_IDX)) |=> !data_out_o)
    else $error("serial output not low after the result");

  cmd_four_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cmd_done |=> st_r.cap_cnt == adc_port_pkg::CMD_BITS)
    else $error("command not complete after four capture edges");

  power_down_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cmd_done && st_nxt.cmd == adc_port_pkg::CMD_POWER_DOWN |=> power_down_o && !sampling_o)
    else $error("power-down command not taken");

  rate_select_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cmd_done && st_nxt.cmd == adc_port_pkg::CMD_SLOW_RATE |=> !fast_rate_o)
    else $error("slow rate not selected");

  hold_result_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    conv_abort |=> $stable(st_r.result) && eoc_o)
    else $error("abort disturbed the held result");

  sample_window_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    sampling_o |-> st_r.armed && st_r.main_cnt > adc_port_pkg::SAMPLE_IDX &&
                   st_r.main_cnt <= adc_port_pkg::CONVERT_IDX)
    else $error("sampling outside the fourth to tenth edge window");

  dsp_rearm_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    st_r.active && st_r.dsp && !cs_lvl && !cs_fall && clk_fall && fs_lvl |=>
    st_r.armed && st_r.main_cnt == '0 && data_out_o == $past(st_r.result[9]))
    else $error("sequencer not restarted by a fall with frame sync high");
endmodule
`default_nettype wire

// [design/adc_port_pkg.sv]
package adc_port_pkg;
  localparam int          CLK_NS         = 50;
  localparam int          FAST_CONV_NS   = 10000;
  localparam int          SLOW_CONV_NS   = 40000;
  localparam int          FAST_CONV_CY   = (FAST_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SLOW_CONV_CY   = (SLOW_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RES_W          = 10;
  localparam int          CMD_W          = 4;
  localparam int          CNT_W          = 5;
  localparam int          CONV_CNT_W     = 10;
  localparam logic [4:0]  CMD_LAST_IDX   = 5'h03;
  localparam logic [4:0]  CMD_BITS       = 5'h04;
  localparam logic [4:0]  SAMPLE_IDX     = 5'h03;
  localparam logic [4:0]  CONVERT_IDX    = 5'h09;
  localparam logic [4:0]  CNT_MAX        = 5'h1f;
  localparam logic [3:0]  CMD_CH_LAST    = 4'h7;
  localparam logic [3:0]  CMD_POWER_DOWN = 4'h8;
  localparam logic [3:0]  CMD_FAST_RATE  = 4'h9;
  localparam logic [3:0]  CMD_SLOW_RATE  = 4'ha;
  localparam logic [3:0]  CMD_TEST_MID   = 4'hb;
  localparam logic [3:0]  CMD_TEST_LOW   = 4'hc;
  localparam logic [3:0]  CMD_TEST_HIGH  = 4'hd;
  localparam logic [9:0]  TEST_MID_CODE  = 10'h200;
  localparam logic [9:0]  TEST_LOW_CODE  = 10'h000;
  localparam logic [9:0]  TEST_HIGH_CODE = 10'h3ff;
  localparam logic [9:0]  RESULT_RESET   = 10'h000;
endpackage

// [design/edge_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  sync_t sy_r;
  sync_t sy_nxt;

  // The first stage feeds only the second stage, so metastability stays contained.
  always_comb begin
    sy_nxt    = sy_r;
    sy_nxt.s1 = async_i;
    sy_nxt.s2 = sy_r.s1;
    sy_nxt.s3 = sy_r.s2;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sy_r <= {INIT, INIT, INIT};
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign level_o = sy_r.s2;
  assign rise_o  = sy_r.s2 & ~sy_r.s3;
  assign fall_o  = ~sy_r.s2 & sy_r.s3;
endmodule
`default_nettype wire

// [design/conversion_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module conversion_timer (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       fast_i,
  input  wire logic [9:0] value_i,
  output logic            busy_o,
  output logic            eoc_o,
  output logic            done_o,
  output logic [9:0]      result_o
);
  localparam int FAST_CY = adc_port_pkg::FAST_CONV_CY;
  localparam int SLOW_CY = adc_port_pkg::SLOW_CONV_CY;
  localparam int SLOW_DONE = SLOW_CY + 1;

  typedef struct packed {
    logic       busy;
    logic       eoc;
    logic       done;
    logic [9:0] cnt;
    logic [9:0] value;
    logic [9:0] result;
  } conv_t;

  conv_t cv_r;
  conv_t cv_nxt;

  always_comb begin
    cv_nxt      = cv_r;
    cv_nxt.done = 1'b0;
    if (abort_i) begin
      cv_nxt.busy = 1'b0;
      cv_nxt.eoc  = 1'b1;
    end else if (start_i) begin
      cv_nxt.busy  = 1'b1;
      cv_nxt.eoc   = 1'b0;
      cv_nxt.value = value_i;
      cv_nxt.cnt   = fast_i ? 10'(FAST_CY - 1) : 10'(SLOW_CY - 1);
    end else if (cv_r.busy) begin
      if (cv_r.cnt == 10'h000) begin
        cv_nxt.busy   = 1'b0;
        cv_nxt.eoc    = 1'b1;
        cv_nxt.done   = 1'b1;
        cv_nxt.result = cv_r.value;
      end else begin
        cv_nxt.cnt = cv_r.cnt - 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cv_r <= {1'b0, 1'b1, 1'b0, 10'h000, 10'h000, 10'h000};
    end else begin
      cv_r <= cv_nxt;
    end
  end

  assign busy_o   = cv_r.busy;
  assign eoc_o    = cv_r.eoc;
  assign done_o   = cv_r.done;
  assign result_o = cv_r.result;

  conv_bounded_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    start_i && !abort_i |-> ##[1:SLOW_DONE] (done_o || abort_i))
    else $error("conversion did not finish within the rate bound");

  eoc_high_done_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    done_o |-> eoc_o && !busy_o && result_o == $past(cv_r.value))
    else $error("result not readable when end of conversion rises");
endmodule
`default_nettype wire

// [verif/host_port_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// Host serial port master, microcontroller or DSP framing.
// ---------------------------------------------------------------------------
module host_port_model (
  input  wire logic sys_clk_i,
  input  wire logic data_out_i,
  input  wire logic data_out_oe_i,
  output logic      cs_n_o,
  output logic      frame_sync_o,
  output logic      io_clk_o,
  output logic      data_in_o
);
  initial begin
    cs_n_o       = 1'b1;
    frame_sync_o = 1'b1;
    io_clk_o     = 1'b0;
    data_in_o    = 1'b0;
  end

  task automatic wait_cy(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // A floating line reads unknown, so a missing enable never passes for data.
  function automatic logic line();
    return data_out_oe_i ? data_out_i : 1'bx;
  endfunction

  task automatic frame(input logic dsp, input logic pol, input logic [3:0] cmd,
                       input int nclk, output logic [15:0] rd);
    logic cap_rise;
    cap_rise = pol ^ dsp;
    rd = 16'h0000;
    wait_cy(1);
    frame_sync_o <= ~dsp;
    wait_cy(4);
    cs_n_o <= 1'b0;
    wait_cy(8);
    if (dsp) begin
      frame_sync_o <= 1'b1;
      wait_cy(4);
      io_clk_o <= 1'b1;
      wait_cy(4);
      io_clk_o <= 1'b0;
      wait_cy(2);
      frame_sync_o <= 1'b0;
      wait_cy(6);
    end
    for (int i = 0; i < nclk; i++) begin
      if (cap_rise && i < 4) data_in_o <= cmd[3 - i];
      wait_cy(3);
      @(negedge sys_clk_i);
      if (dsp) rd[15 - i] = line();
      @(posedge sys_clk_i);
      io_clk_o <= 1'b1;
      if (!cap_rise && i < 4) data_in_o <= cmd[3 - i];
      wait_cy(3);
      @(negedge sys_clk_i);
      if (!dsp) rd[15 - i] = line();
      @(posedge sys_clk_i);
      io_clk_o <= 1'b0;
    end
    wait_cy(4);
    cs_n_o <= 1'b1;
    data_in_o <= ~data_in_o;
    frame_sync_o <= 1'b1;
    wait_cy(8);
  endtask
endmodule
`default_nettype wire

// [verif/adc_serial_control_port_test.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// Command and readout sequences through the host model.
// ---------------------------------------------------------------------------
module adc_serial_control_port_test;
  logic       sys_clk;
  logic       reset;
  logic       pol;
  logic       four;
  logic [9:0] code;
  logic       cs_n;
  logic       fs;
  logic       io_clk;
  logic       din;
  logic       dout;
  logic       oe;
  logic       eoc;
  logic [2:0] ch;
  logic       pd;
  logic       fr;
  logic       fr_exp;
  logic       samp;
  int         samp_cnt = 0;
  int         failures;
  int         compares;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Counts the cycles in which the sampling window is open.
  always @(posedge sys_clk) begin
    if (samp === 1'b1) samp_cnt <= samp_cnt + 1;
  end

  adc_serial_control_port adc_serial_control_port_inst (
    .sys_clk_i              (sys_clk),
    .reset_i                (reset),
    .cs_n_i                 (cs_n),
    .frame_sync_i           (fs),
    .io_clk_i               (io_clk),
    .data_in_i              (din),
    .clock_polarity_select_i(pol),
    .four_input_variant_i   (four),
    .analog_code_i          (code),
    .data_out_o             (dout),
    .data_out_oe_o          (oe),
    .eoc_o                  (eoc),
    .channel_o              (ch),
    .sampling_o             (samp),
    .power_down_o           (pd),
    .fast_rate_o            (fr)
  );

  host_port_model host_port_model_inst (
    .sys_clk_i    (sys_clk),
    .data_out_i   (dout),
    .data_out_oe_i(oe),
    .cs_n_o       (cs_n),
    .frame_sync_o (fs),
    .io_clk_o     (io_clk),
    .data_in_o    (din)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Limit -1 leaves a conversion running so that the next frame aborts it.
  task automatic run(input logic dsp, input logic p, input logic f, input logic [9:0] c,
                     input logic [3:0] cmd, input int n, input logic [9:0] exp,
                     input int lo, input int lim);
    logic [15:0] rd;
    logic [15:0] mask;
    int          cnt;
    int          s0;
    @(posedge sys_clk);
    s0 = samp_cnt;
    pol  <= p;
    four <= f;
    code <= c;
    host_port_model_inst.frame(dsp, p, cmd, n, rd);
    @(negedge sys_clk);
    mask = 16'hffff << (16 - n);
    chk(rd & mask, {exp, 6'h00} & mask);
    chk(16'(oe), 16'h0000);
    chk(16'((samp_cnt - s0 > 40) && (samp_cnt - s0 <= 48)), 16'(lim != 0));
    chk(16'(pd), 16'(cmd == 4'h8));
    if (cmd == 4'h9) fr_exp = 1'b1;
    if (cmd == 4'ha) fr_exp = 1'b0;
    chk(16'(fr), 16'(fr_exp));
    if (cmd < 4'h8) chk(16'(ch), 16'(f ? {1'b0, cmd[2:1]} : cmd[2:0]));
    if (lim == 0) begin
      chk(16'(eoc), 16'h0001);
    end else begin
      chk(16'(eoc), 16'h0000);
      if (lim > 0) begin
        for (cnt = 0; cnt < lim && eoc !== 1'b1; cnt++) @(negedge sys_clk);
        if (cnt == lim) begin
          failures++;
          print_verdict();
        end
        chk(16'(cnt > lo), 16'h0001);
      end
    end
    $display("test with command %h done", cmd);
  endtask

  initial begin
    reset    = 1'b1;
    pol      = 1'b1;
    four     = 1'b0;
    code     = 10'h000;
    fr_exp   = 1'b0;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({12'h000, eoc, oe, pd, fr}, 16'h0008);
    run(1'b0, 1'b1, 1'b0, 10'h000, 4'hd, 12, 10'h000, 600, 830);
    run(1'b0, 1'b0, 1'b0, 10'h000, 4'hb, 10, 10'h3ff, 600, 830);
    run(1'b1, 1'b1, 1'b0, 10'h000, 4'h9, 16, 10'h200, 0, 0);
    run(1'b1, 1'b0, 1'b0, 10'h000, 4'hc, 16, 10'h200, 100, 230);
    run(1'b0, 1'b1, 1'b0, 10'h2a5, 4'h5, 11, 10'h000, 100, 230);
    run(1'b0, 1'b0, 1'b0, 10'h2a5, 4'ha, 10, 10'h2a5, 0, 0);
    run(1'b0, 1'b1, 1'b0, 10'h2a5, 4'h8, 10, 10'h2a5, 0, 0);
    run(1'b0, 1'b1, 1'b1, 10'h155, 4'h6, 10, 10'h2a5, 600, 830);
    run(1'b0, 1'b1, 1'b1, 10'h0aa, 4'h3, 10, 10'h155, 0, 0);
    run(1'b0, 1'b1, 1'b0, 10'h0aa, 4'hf, 10, 10'h155, 0, 0);
    run(1'b0, 1'b1, 1'b0, 10'h0aa, 4'hd, 10, 10'h155, -1, -1);
    run(1'b0, 1'b1, 1'b0, 10'h0aa, 4'he, 10, 10'h155, 0, 0);
    run(1'b0, 1'b1, 1'b0, 10'h0aa, 4'h7, 10, 10'h155, 600, 830);
    run(1'b0, 1'b1, 1'b0, 10'h0aa, 4'he, 10, 10'h0aa, 0, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
